/* File: testbench/video_port_output_window_asserts.sv */
// checker of readback and sync pulse timing at the block ports
`timescale 1ns/10ps
`include "video_port_regs.vh"
module video_port_output_window_asserts (
    input wire clk,
    input wire rst_n,
    input wire [`ADDR_W-1:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    input wire [31:0] regRdata,
    input wire inputVerticalSync,
    input wire portValid,
    input wire portVerticalSync,
    input wire portHorizontalSync
);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
// shadow of the output window, kept to judge readback
reg [31:0] outWin_r;
always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        outWin_r <= 32'h0;
    else if (regWr && regAddr == `OFS_OUT_WIN)
        outWin_r <= regWdata & `OUT_W_MASK;
end
chk_rd_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
chk_out_readback: assert property ($past(regRd && regAddr == `OFS_OUT_WIN)
    |-> regRdata == $past(outWin_r)) else $error("output window readback wrong");
chk_vs_follows: assert property ($rose(inputVerticalSync) |-> ##[2:4] portVerticalSync)
    else $error("no output vsync after input vsync");
chk_vs_caused: assert property (portVerticalSync |-> $past(inputVerticalSync, 2)
    || $past(inputVerticalSync, 3) || $past(inputVerticalSync, 4)) else $error("stray vsync");
chk_vs_single: assert property (portVerticalSync |=> !portVerticalSync)
    else $error("vsync longer than one cycle");
chk_hs_with_pixel: assert property (portHorizontalSync |-> portValid)
    else $error("hsync without first pixel");
chk_hs_single: assert property (portHorizontalSync |=> !portHorizontalSync)
    else $error("hsync longer than one cycle");
chk_reset_quiet: assert property ($rose(rst_n) |-> !portValid && regRdata == 32'h0)
    else $error("outputs busy right after reset");
endmodule // video_port_output_window_asserts
bind video_port_output_window video_port_output_window_asserts i_chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .inputVerticalSync(inputVerticalSync), .portValid(portValid),
    .portVerticalSync(portVerticalSync), .portHorizontalSync(portHorizontalSync));

/* File: testbench/video_port_output_window_tb.sv */
// testbench of the video port output window
`timescale 1ns/10ps
module video_port_output_window_tb;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg [3:0] regAddr = 4'h0;
reg [31:0] regWdata = 32'h0;
reg regWr = 1'b0;
reg regRd = 1'b0;
reg vs = 1'b0;
reg hs = 1'b0;
wire [31:0] regRdata;
wire [9:0] portPixel;
wire portValid;
wire portVerticalSync;
wire portHorizontalSync;
integer errors = 0;
integer checked = 0;
integer cycles = 0;
always #20 clk = ~clk;
video_port_output_window i_video_port_output_window (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .videoIn(16'hb6d9), .inputVerticalSync(vs), .inputHorizontalSync(hs), .portPixel(portPixel),
    .portValid(portValid), .portVerticalSync(portVerticalSync),
    .portHorizontalSync(portHorizontalSync));
video_sink_model i_video_sink_model (.clk(clk), .portPixel(portPixel), .portValid(portValid),
    .portVerticalSync(portVerticalSync), .portHorizontalSync(portHorizontalSync));
////////////////////////////////////////////////////////////////////////////////
task cmp(input [31:0] got, input [31:0] exp);
begin
    checked = checked + 1;
    if (got !== exp)
    begin
        errors = errors + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
end
endtask
task wr(input [3:0] a, input [31:0] d);
begin
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
end
endtask
task rd(input [3:0] a, input [31:0] exp);
begin
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 cmp(regRdata, exp);
end
endtask
// one input frame: a long vsync, then n lines of 30 pixel slots each
task frame(input integer n);
    integer l;
begin
    vs <= 1'b1;
    repeat (4) @(posedge clk);
    vs <= 1'b0;
    repeat (4) @(posedge clk);
    for (l = 0; l < n; l = l + 1)
    begin
        hs <= 1'b1;
        repeat (2) @(posedge clk);
        hs <= 1'b0;
        repeat (30) @(posedge clk);
    end
end
endtask
////////////////////////////////////////////////////////////////////////////////
task test_regs;
begin
    rd(4'h8, 32'h0);
    wr(4'h8, 32'hffffffff);
    rd(4'h8, 32'h7fffffff);
    wr(4'h4, 32'hffffffff);
    rd(4'h4, 32'h1fff1fff);
    wr(4'h0, 32'hffffffff);
    rd(4'h0, 32'h1fff1fff);
    wr(4'hc, 32'hffffffff);
    rd(4'hc, 32'h00007000);
    rd(4'h6, 32'h0);
    $display("register test done");
end
endtask
// crop 20 pixels from sp and lines 1..6 of 8, then frame the output window
// sp above zero moves the output start past what the 4-bit offset reaches
task test_window(input [2:0] sel, input [3:0] off, input [12:0] sp, input [12:0] pix,
    input [13:0] nl, input integer expPix);
    integer f;
    reg [2:0] s;
begin
    s = (sel == 3'h7) ? 3'h6 : sel;
    wr(4'h0, {3'h0, sp, 16'h0014});
    wr(4'h4, 32'h00010006);
    wr(4'h8, {1'b0, nl, pix, off});
    wr(4'hc, {17'h0, sel, 12'h0});
    f = i_video_sink_model.frames;
    frame(8);
    repeat (10) @(posedge clk);
    cmp(i_video_sink_model.frames - f, 1);
    cmp(i_video_sink_model.lines, nl);
    cmp(i_video_sink_model.pixels, nl * expPix);
    cmp(i_video_sink_model.lastPixel, (16'hb6d9 >> (6 - s)) & 32'h000003ff);
    rd(4'h1, {17'h0, 1'b1, nl});
    $display("window test done");
end
endtask
task give_verdict;
begin
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
end
endtask
always @(posedge clk)
begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
        errors = errors + 1;
        give_verdict;
    end
end
initial
begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    test_regs;
    test_window(3'h0, 4'h3, 13'h0000, 13'h0008, 14'h4, 8);
    test_window(3'h6, 4'hf, 13'h0004, 13'h0008, 14'h4, 5);
    test_window(3'h7, 4'h0, 13'h0000, 13'h1fff, 14'h3, 20);
    give_verdict;
end
endmodule // video_port_output_window_tb

/* File: testbench/video_sink_model.sv */
// downstream engines: count frames, lines and pixels of the port stream
`timescale 1ns/10ps
module video_sink_model (
    input wire clk,
    input wire [9:0] portPixel,
    input wire portValid,
    input wire portVerticalSync,
    input wire portHorizontalSync
);
integer frames = 0;
integer lines = 0;
integer pixels = 0;
reg [9:0] lastPixel = 10'h0;
// line and pixel counts restart on each output vsync, as a consumer would; frames keeps counting
always @(posedge clk)
begin
    frames <= frames + portVerticalSync;
    lines <= portVerticalSync ? 0 : lines + portHorizontalSync;
    pixels <= portVerticalSync ? 0 : pixels + portValid;
    if (portValid)
        lastPixel <= portPixel;
end
endmodule // video_sink_model

/* File: verilog/input_bit_select.v */
// picks 10 bits of the 16-bit input bus and registers them
`timescale 1ns/10ps
`include "video_port_regs.vh"
module input_bit_select #(
    parameter IN_W = 16,
    parameter OUT_W = 10
) (
    input wire clk,
    input wire rst_n,
    input wire [IN_W-1:0] busIn,
    input wire [2:0] sel,
    output reg [OUT_W-1:0] pixelOut
);
    // code 0 takes the top bits, each step down one; reserved code holds lowest
    wire [2:0] shiftSel;
    wire [IN_W-1:0] shifted;

    assign shiftSel = (sel > `SEL_MAX) ? `SEL_MAX : sel;
    assign shifted = busIn >> (`SEL_MAX - shiftSel);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pixelOut <= {OUT_W{1'b0}};
        else
            pixelOut <= shifted[OUT_W-1:0];
    end
endmodule // input_bit_select

/* File: verilog/video_port_output_window.v */
// video port output window: reformatter crop plus output framing
//
// Contract
// - 13-bit start line from input vertical sync
// - 13-bit count of accepted lines
// - output at most the programmed line count
// - output feeds preview, statistics, histogram
// - output vsync from each input vsync rise
// - output at most programmed pixel count each line
// - 4-bit offset starts output hsync
// - 13-bit start pixel and pixel count
// - 3-bit select picks 10 input bits
`timescale 1ns/10ps
`include "video_port_regs.vh"
module video_port_output_window #(
    parameter IN_W = 16,
    parameter PIX_W = 10
) (
    input wire clk,
    input wire rst_n,
    input wire [`ADDR_W-1:0] regAddr,
    input wire [31:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdata,
    input wire [IN_W-1:0] videoIn,
    input wire inputVerticalSync,
    input wire inputHorizontalSync,
    output reg [PIX_W-1:0] portPixel,
    output reg portValid,
    output reg portVerticalSync,
    output reg portHorizontalSync
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [31:0] horzWin_r;
    reg [31:0] vertWin_r;
    reg [31:0] outWin_r;
    reg [31:0] inSel_r;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            horzWin_r <= `WIN_RESET;
            vertWin_r <= `WIN_RESET;
            outWin_r <= `WIN_RESET;
            inSel_r <= `WIN_RESET;
        end
        else if (regWr)
        begin
            case (regAddr)
                `OFS_HORZ_WIN: horzWin_r <= regWdata & `WIN_W_MASK;
                `OFS_VERT_WIN: vertWin_r <= regWdata & `WIN_W_MASK;
                `OFS_OUT_WIN: outWin_r <= regWdata & `OUT_W_MASK;
                `OFS_IN_SEL: inSel_r <= regWdata & `SEL_W_MASK;
                default: ;
            endcase
        end
    end

    wire [12:0] startPixel = horzWin_r[`START_HI:`START_LO];
    wire [12:0] pixelCount = horzWin_r[`LEN_HI:`LEN_LO];
    wire [12:0] startLine = vertWin_r[`START_HI:`START_LO];
    wire [12:0] lineCount = vertWin_r[`LEN_HI:`LEN_LO];
    wire [13:0] outLines = outWin_r[`OLC_HI:`OLC_LO];
    wire [12:0] outPixels = outWin_r[`OPC_HI:`OPC_LO];
    wire [3:0] outOffset = outWin_r[`OFF_HI:`OFF_LO];

    ////////////////////////////////////////////////////////////////////////
    // input sync and data alignment
    reg vs1_r, vs2_r, vs3_r, hs1_r, hs2_r, hs3_r;
    reg [IN_W-1:0] d1_r;
    reg [IN_W-1:0] d2_r;
    wire [PIX_W-1:0] selPixel;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {vs1_r, vs2_r, vs3_r, hs1_r, hs2_r, hs3_r} <= 6'h00;
            d1_r <= {IN_W{1'b0}};
            d2_r <= {IN_W{1'b0}};
        end
        else
        begin
            vs1_r <= inputVerticalSync;
            vs2_r <= vs1_r;
            vs3_r <= vs2_r;
            hs1_r <= inputHorizontalSync;
            hs2_r <= hs1_r;
            hs3_r <= hs2_r;
            d1_r <= videoIn;
            d2_r <= d1_r;
        end
    end

    // selector adds one cycle, so sync is compared one stage later too
    input_bit_select #(.IN_W(IN_W), .OUT_W(PIX_W)) bitSel (
        .clk(clk),
        .rst_n(rst_n),
        .busIn(d2_r),
        .sel(inSel_r[`SEL_HI:`SEL_LO]),
        .pixelOut(selPixel)
    );

    wire vsRise = vs2_r & ~vs3_r;
    wire hsRise = hs2_r & ~hs3_r;

    ////////////////////////////////////////////////////////////////////////
    // counters: input line/pixel and output line/pixel
    reg [12:0] inLine_r;
    reg [12:0] inPix_r;
    reg [13:0] outLine_r;
    reg [12:0] outPix_r;
    reg lineOpen_r;
    reg frameOn_r;
    reg hsPend_r;

    function inRange;
        input [12:0] pos;
        input [12:0] first;
        input [12:0] len;
        begin
            inRange = ({1'b0, pos} >= {1'b0, first}) &&
                ({1'b0, pos} < ({1'b0, first} + {1'b0, len}));
        end
    endfunction

    wire lineOk = inRange(inLine_r, startLine, lineCount);
    wire pixOk = inRange(inPix_r, startPixel, pixelCount);
    // offset counted from the first accepted pixel of each line
    wire [13:0] relPix = {1'b0, inPix_r} - {1'b0, startPixel};
    wire atOffset = pixOk && (relPix == {10'h000, outOffset});
    wire lineDone = outLine_r >= outLines;
    wire pixGo = frameOn_r && lineOk && lineOpen_r && !lineDone &&
        pixOk && (relPix >= {10'h000, outOffset}) &&
        (outPix_r < outPixels);

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inLine_r <= 13'h0000;
            inPix_r <= 13'h0000;
            outLine_r <= 14'h0000;
            outPix_r <= 13'h0000;
            lineOpen_r <= 1'b0;
            frameOn_r <= 1'b0;
            hsPend_r <= 1'b0;
            portPixel <= {PIX_W{1'b0}};
            portValid <= 1'b0;
            portVerticalSync <= 1'b0;
            portHorizontalSync <= 1'b0;
        end
        else
        begin
            portVerticalSync <= vsRise;
            portHorizontalSync <= 1'b0;
            portValid <= 1'b0;
            if (vsRise)
            begin
                inLine_r <= 13'h0000;
                inPix_r <= 13'h0000;
                outLine_r <= 14'h0000;
                outPix_r <= 13'h0000;
                lineOpen_r <= 1'b0;
                frameOn_r <= 1'b1;
                hsPend_r <= 1'b0;
            end
            else if (hsRise)
            begin
                inPix_r <= 13'h0000;
                if (lineOpen_r)
                    inLine_r <= inLine_r + 13'h0001;
                // a line that emitted pixels counts as one output line
                if (outPix_r != 13'h0000)
                    outLine_r <= outLine_r + 14'h0001;
                outPix_r <= 13'h0000;
                lineOpen_r <= 1'b1;
                hsPend_r <= 1'b1;
            end
            else
            begin
                inPix_r <= inPix_r + 13'h0001;
                if (hsPend_r && atOffset && frameOn_r && lineOk && !lineDone)
                begin
                    portHorizontalSync <= 1'b1;
                    hsPend_r <= 1'b0;
                end
                if (pixGo)
                begin
                    portValid <= 1'b1;
                    portPixel <= selPixel;
                    outPix_r <= outPix_r + 13'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdata <= 32'h00000000;
        else if (regRd)
        begin
            case (regAddr)
                `OFS_HORZ_WIN: regRdata <= horzWin_r;
                `OFS_VERT_WIN: regRdata <= vertWin_r;
                `OFS_OUT_WIN: regRdata <= outWin_r;
                `OFS_IN_SEL: regRdata <= inSel_r;
                // status: output line reached and frame active
                `OFS_STATUS: regRdata <= {17'h00000, frameOn_r, outLine_r};
                default: regRdata <= 32'h00000000;
            endcase
        end
        else
            regRdata <= 32'h00000000;
    end
endmodule // video_port_output_window

/* File: verilog/video_port_regs.vh */
// register offsets, field positions and reset values of the video port output window
`ifndef VIDEO_PORT_REGS_VH
`define VIDEO_PORT_REGS_VH

`define ADDR_W 4
`define OFS_HORZ_WIN 4'h0
`define OFS_VERT_WIN 4'h4
`define OFS_OUT_WIN 4'h8
`define OFS_IN_SEL 4'hc
`define OFS_STATUS 4'h1

`define START_HI 28
`define START_LO 16
`define LEN_HI 12
`define LEN_LO 0
`define OLC_HI 30
`define OLC_LO 17
`define OPC_HI 16
`define OPC_LO 4
`define OFF_HI 3
`define OFF_LO 0
`define SEL_HI 14
`define SEL_LO 12
`define SEL_MAX 3'h6

`define WIN_RESET 32'h00000000
`define WIN_W_MASK 32'h1fff1fff
`define OUT_W_MASK 32'h7fffffff
`define SEL_W_MASK 32'h00007000

`endif
